// ===== core/hbcr_regs.sv
// Header type, self-test stub and system configuration register bank.
// Assumes byte reads/writes on clk; straps and power_good are async pins.
`default_nettype none
module hbcr_regs
    import hbcr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata_q,
    input wire logic power_good,
    input wire logic row_select_strap_pin,
    input wire logic [1:0] freq_strap_pins,
    input wire logic host_addr_bit7,
    output hbcr_cfg_t cfg_q,
    output logic freq_60_q,
    output logic freq_66_q
);
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic row_strap_q;
    logic [1:0] freq_strap_q;
    logic qdepth_q;
    logic proto_off_q;
    logic test_mode_q;
    hbcr_integrity_t integ_mode_q;
    logic pg_prev_q;
    logic pg_rise;
    logic [15:0] syscfg;

    function automatic logic [15:0] pack_syscfg(input hbcr_cfg_t c);
        logic [15:0] v;
        v = 16'h0000;
        v[HBCR_BIT_PROTO_OFF] = c.dual_cpu_protocol_off;
        v[HBCR_BIT_ROW_STRAP] = c.extra_row_select_strap;
        v[HBCR_BIT_FREQ_LO +: 2] = c.host_freq_strap;
        v[HBCR_BIT_TEST] = c.integrity_test_mode;
        v[HBCR_BIT_MODE_LO +: 2] = c.data_integrity_mode;
        v[HBCR_BIT_QDEPTH] = c.queue_depth_strap;
        return v;
    endfunction

    // Pins first pass two flops; only the second stage is read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            pg_prev_q <= 1'b0;
        end else if (ce) begin
            sync1_q <= {power_good, row_select_strap_pin, freq_strap_pins,
                        host_addr_bit7};
            sync2_q <= sync1_q;
            pg_prev_q <= sync2_q[4];
        end
    end

    assign pg_rise = sync2_q[4] && !pg_prev_q;

    // Straps held from power-good rise onward, not writable
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            row_strap_q <= 1'b0;
            freq_strap_q <= 2'h0;
            qdepth_q <= 1'b0;
        end else if (ce && pg_rise) begin
            row_strap_q <= sync2_q[3];
            freq_strap_q <= sync2_q[2:1];
            qdepth_q <= !sync2_q[0];
        end
    end

    // Software fields; writes to header/self-test land nowhere
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            proto_off_q <= HBCR_RST_PROTO_OFF;
            test_mode_q <= HBCR_RST_TEST;
            integ_mode_q <= hbcr_integrity_t'(HBCR_RST_MODE);
        end else if (ce && cfg_wr) begin
            if (cfg_addr == HBCR_OFS_SYSCFG_HI) begin
                proto_off_q <= cfg_wdata[7];
            end
            if (cfg_addr == HBCR_OFS_SYSCFG_LO) begin
                test_mode_q <= cfg_wdata[6];
                integ_mode_q <=
                    hbcr_integrity_t'(cfg_wdata[5:4]);
            end
        end
    end

    // Pure wiring: each field keeps a single driving flop
    assign cfg_q = '{
        dual_cpu_protocol_off: proto_off_q,
        extra_row_select_strap: row_strap_q,
        host_freq_strap: freq_strap_q,
        integrity_test_mode: test_mode_q,
        data_integrity_mode: integ_mode_q,
        queue_depth_strap: qdepth_q
    };

    // Frequency decode; reserved codes give neither flag
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            freq_60_q <= 1'b0;
            freq_66_q <= 1'b0;
        end else if (ce) begin
            freq_60_q <= (cfg_q.host_freq_strap == HBCR_FREQ_60);
            freq_66_q <= (cfg_q.host_freq_strap == HBCR_FREQ_66);
        end
    end

    assign syscfg = pack_syscfg(cfg_q);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_rdata_q <= 8'h00;
        end else if (ce && cfg_rd) begin
            case (cfg_addr)
                HBCR_OFS_HEADER: cfg_rdata_q <= HBCR_HEADER_FORMAT_CODE;
                HBCR_OFS_SELFTEST: cfg_rdata_q <= HBCR_SELFTEST_VAL;
                HBCR_OFS_SYSCFG_LO: cfg_rdata_q <= syscfg[7:0];
                HBCR_OFS_SYSCFG_HI: cfg_rdata_q <= syscfg[15:8];
                default: cfg_rdata_q <= 8'h00;
            endcase
        end
    end

    chk_header_reads_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && cfg_rd && cfg_addr == HBCR_OFS_HEADER |=> cfg_rdata_q == 8'h00)
        else $error("header type not zero");
    chk_selftest_reads_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && cfg_rd && cfg_addr == HBCR_OFS_SELFTEST |=> cfg_rdata_q == 8'h00)
        else $error("self-test byte not zero");
    chk_proto_bit_write: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && cfg_wr && cfg_addr == HBCR_OFS_SYSCFG_HI
        |=> cfg_q.dual_cpu_protocol_off == $past(cfg_wdata[7]))
        else $error("protocol bit not written");
    chk_row_strap_latch: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && pg_rise |=> cfg_q.extra_row_select_strap == $past(sync2_q[3]))
        else $error("row strap not latched");
    chk_freq_strap_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        !pg_rise |=> $stable(cfg_q.host_freq_strap))
        else $error("frequency strap changed without power-good");
    chk_freq_decode: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && cfg_q.host_freq_strap == 2'h2 |=> freq_66_q && !freq_60_q)
        else $error("66 MHz decode wrong");
    chk_test_mode_persist: assert property (
        @(posedge clk) disable iff (!nrst)
        cfg_q.integrity_test_mode && !(cfg_wr && cfg_addr == HBCR_OFS_SYSCFG_LO)
        |=> cfg_q.integrity_test_mode)
        else $error("test mode dropped without write");
    chk_mode_write: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && cfg_wr && cfg_addr == HBCR_OFS_SYSCFG_LO
        |=> cfg_q.data_integrity_mode == $past(cfg_wdata[5:4]))
        else $error("integrity mode not written");
    chk_qdepth_invert: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && pg_rise |=> cfg_q.queue_depth_strap == !$past(sync2_q[0]))
        else $error("queue depth strap not inverted");
    chk_reserved_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && cfg_rd && cfg_addr == HBCR_OFS_SYSCFG_HI
        |=> cfg_rdata_q[5:2] == 4'h0)
        else $error("reserved bits not zero");

    chk_header_write_inert: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && cfg_wr && cfg_addr == HBCR_OFS_HEADER && !pg_rise
        |=> $stable(cfg_q))
        else $error("header write changed state");
    chk_selftest_write_inert: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && cfg_wr && cfg_addr == HBCR_OFS_SELFTEST && !pg_rise
        |=> $stable(cfg_q))
        else $error("self-test write changed state");
    chk_proto_bit_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        !(ce && cfg_wr && cfg_addr == HBCR_OFS_SYSCFG_HI)
        |=> $stable(cfg_q.dual_cpu_protocol_off))
        else $error("protocol bit changed without write");
    chk_row_strap_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        !(ce && pg_rise) |=> $stable(cfg_q.extra_row_select_strap))
        else $error("row strap changed without power-good");
    chk_freq_decode_60: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && cfg_q.host_freq_strap == HBCR_FREQ_60
        |=> freq_60_q && !freq_66_q)
        else $error("60 MHz decode wrong");
    chk_freq_reserved_code: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && cfg_q.host_freq_strap != HBCR_FREQ_60
        && cfg_q.host_freq_strap != HBCR_FREQ_66
        |=> !freq_60_q && !freq_66_q)
        else $error("reserved frequency code decoded");
    chk_test_mode_write: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && cfg_wr && cfg_addr == HBCR_OFS_SYSCFG_LO
        |=> cfg_q.integrity_test_mode == $past(cfg_wdata[6]))
        else $error("test mode not written");
    chk_mode_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        !(ce && cfg_wr && cfg_addr == HBCR_OFS_SYSCFG_LO)
        |=> $stable(cfg_q.data_integrity_mode))
        else $error("integrity mode changed without write");
    chk_qdepth_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        !(ce && pg_rise) |=> $stable(cfg_q.queue_depth_strap))
        else $error("queue depth changed without power-good");
    chk_reserved_low: assert property (
        @(posedge clk) disable iff (!nrst)
        ce && cfg_rd && cfg_addr == HBCR_OFS_SYSCFG_LO
        |=> {cfg_rdata_q[7], cfg_rdata_q[3], cfg_rdata_q[1:0]} == 4'h0)
        else $error("reserved low bits not zero");
    // Low enable must freeze cfg_q, read data and the 60 MHz flag
    chk_ce_freeze: assert property (
        @(posedge clk) disable iff (!nrst)
        !ce |=> $stable(cfg_q) && $stable(cfg_rdata_q) && $stable(freq_60_q))
        else $error("state changed with clock enable low");

    cov_power_good_rise: cover property (@(posedge clk) ce && pg_rise);
    cov_ecc_correct: cover property (@(posedge clk)
        cfg_q.data_integrity_mode == HBCR_DI_ECC_CORRECT);
    cov_test_mode_on: cover property (@(posedge clk)
        cfg_q.integrity_test_mode);
    cov_protocol_off: cover property (@(posedge clk)
        cfg_q.dual_cpu_protocol_off);
    cov_freq_66: cover property (@(posedge clk) freq_66_q);
endmodule
`default_nettype wire

// ===== pkg/hbcr_pkg.sv
// Constants and carrier types for the host bridge configuration registers.
// Assumes a byte-wide configuration access port on the core clock.
`default_nettype none
package hbcr_pkg;
    localparam logic [7:0] HBCR_OFS_HEADER = 8'h0E;
    localparam logic [7:0] HBCR_OFS_SELFTEST = 8'h0F;
    localparam logic [7:0] HBCR_OFS_SYSCFG_LO = 8'h50;
    localparam logic [7:0] HBCR_OFS_SYSCFG_HI = 8'h51;
    localparam logic [7:0] HBCR_HEADER_FORMAT_CODE = 8'h00;
    localparam logic [7:0] HBCR_SELFTEST_VAL = 8'h00;
    localparam int HBCR_BIT_PROTO_OFF = 15;
    localparam int HBCR_BIT_ROW_STRAP = 14;
    localparam int HBCR_BIT_FREQ_LO = 8;
    localparam int HBCR_BIT_TEST = 6;
    localparam int HBCR_BIT_MODE_LO = 4;
    localparam int HBCR_BIT_QDEPTH = 2;
    localparam logic HBCR_RST_PROTO_OFF = 1'b0;
    localparam logic HBCR_RST_TEST = 1'b0;
    localparam logic [1:0] HBCR_RST_MODE = 2'h0;
    localparam logic [1:0] HBCR_FREQ_60 = 2'h1;
    localparam logic [1:0] HBCR_FREQ_66 = 2'h2;

    typedef enum logic [1:0] {
        HBCR_DI_NONE = 2'b00,
        HBCR_DI_PARITY = 2'b01,
        HBCR_DI_ECC_DETECT = 2'b10,
        HBCR_DI_ECC_CORRECT = 2'b11
    } hbcr_integrity_t;

    typedef struct packed {
        logic dual_cpu_protocol_off;
        logic extra_row_select_strap;
        logic [1:0] host_freq_strap;
        logic integrity_test_mode;
        hbcr_integrity_t data_integrity_mode;
        logic queue_depth_strap;
    } hbcr_cfg_t;
endpackage
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the bridge configuration register bank.
// Drives the byte port and strap pins itself; assertions live in the core.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import hbcr_pkg::*;
    logic clk = 0, nrst = 0, ce = 1, wr = 0, rd = 0;
    logic pg = 0, row = 0, a7 = 0;
    logic [1:0] fp = 2'h0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
    hbcr_cfg_t cfg;
    logic f60, f66;
    int failures = 0, samples_checked = 0;
    int m_po = 0, m_tm = 0, m_dm = 0, m_row = 0, m_fr = 0, m_qd = 0;
    logic [31:0] rs = 32'h37;
    logic [15:0] e;
    hbcr_regs dut (.clk(clk), .nrst(nrst), .ce(ce), .cfg_wr(wr),
        .cfg_rd(rd), .cfg_addr(addr), .cfg_wdata(wd), .cfg_rdata_q(rdata),
        .power_good(pg), .row_select_strap_pin(row),
        .freq_strap_pins(fp), .host_addr_bit7(a7), .cfg_q(cfg),
        .freq_60_q(f60), .freq_66_q(f66));
    always #5 clk = ~clk;
    task automatic print_verdict();
        if (failures == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        v = v ^ (v << 5);
        return v;
    endfunction
    // One strobe cycle; read data settles before the next falling edge
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(negedge clk);
        wr = w;
        rd = !w;
        addr = a;
        wd = d;
        @(negedge clk);
        wr = 0;
        rd = 0;
    endtask
    task automatic rdcfg();
        e = {m_po[0], m_row[0], 4'h0, m_fr[1:0], 1'b0, m_tm[0],
            m_dm[1:0], 1'b0, m_qd[0], 2'h0};
        acc(0, 8'h50, 8'h00);
        chk({8'h00, rdata}, {8'h00, e[7:0]}, "config low byte");
        acc(0, 8'h51, 8'h00);
        chk({8'h00, rdata}, {8'h00, e[15:8]}, "config high byte");
        chk(16'(cfg), {8'h00, e[15:14], e[9:8], e[6:4], e[2]}, "cfg");
    endtask
    // Straps held stable well around the power-good rise
    task automatic straps(input logic r, input logic [1:0] f, input logic a);
        @(negedge clk);
        row = r;
        fp = f;
        a7 = a;
        repeat (3) @(negedge clk);
        pg = 1;
        repeat (6) @(negedge clk);
        m_row = r;
        m_fr = f;
        m_qd = !a;
        chk({f60, f66}, {f == 2'h1, f == 2'h2}, "freq decode");
        pg = 0;
        repeat (4) @(negedge clk);
        row = !r;
        fp = ~f;
        a7 = !a;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        print_verdict();
    end
    initial begin
        repeat (8) @(negedge clk);
        nrst = 1;
        rdcfg();
        for (int i = 0; i < 4; i++) begin
            rs = xs(rs);
            acc(1, 8'h0E + 8'(i % 2), rs[7:0]);
            rdcfg();
            acc(0, 8'h0E, 8'h00);
            chk({8'h00, rdata}, 16'h0000, "header type");
            acc(0, 8'h0F, 8'h00);
            chk({8'h00, rdata}, 16'h0000, "self test");
            acc(0, 8'h40 + rs[11:8], 8'h00);
            chk({8'h00, rdata}, 16'h0000, "unmapped read");
        end
        for (int i = 0; i < 24; i++) begin
            rs = xs(rs);
            acc(1, 8'h50 + 8'(rs[8]), rs[7:0]);
            if (rs[8]) m_po = rs[7];
            else begin
                m_tm = rs[6];
                m_dm = rs[5:4];
            end
            rdcfg();
        end
        // Single-CPU setup, then firmware's integrity choice
        acc(1, HBCR_OFS_SYSCFG_HI, 8'h80);
        m_po = 1;
        acc(1, HBCR_OFS_SYSCFG_LO, {2'h0, HBCR_DI_ECC_CORRECT, 4'h0});
        m_tm = 0;
        m_dm = 3;
        rdcfg();
        for (int i = 0; i < 4; i++) begin
            rs = xs(rs);
            straps(rs[0], 2'(i), rs[1]);
            rdcfg();
        end
        // Clock enable low must freeze the register
        ce = 0;
        acc(1, 8'h51, {~m_po[0], 7'h7F});
        ce = 1;
        rdcfg();
        nrst = 0;
        repeat (2) @(negedge clk);
        nrst = 1;
        {m_po, m_tm, m_dm, m_row, m_fr, m_qd} = '0;
        rdcfg();
        print_verdict();
    end
endmodule
`default_nettype wire
